// ==== logic/pfcpm_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - run bit7 clear off, set on
// - margin level 00, bit6 reads zero
// - margin fault response fixed 01
// - config bit4 picks always-on or controlled
// - config bit3 gates on run bit
// - config bit2 gates on control pin
// - config bit1 sets pin active level
// - config bit0 reads one; fast off
// - code 03 clears all faults together
// - lock bit7 allows only lock writes
// - lock bit6 allows lock, run, erase
// - lock bit5 adds config and setpoint
// - code 12 loads factory defaults
// - code 15 stores operating memory
// - code 16 loads the stored user setpoint
// - feature report read-only, pec 0, speed 01
// - feature bit4 alert reads zero
// - format mode read-only, exponent writable
// - setpoint 12-bit mantissa, top zero
// - loop scale exponent, mantissa, bit10 zero
// - monitor scale exponent, mantissa, bits 15:14 and bit10 zero
// - thresholds show shared input exponent
// - convert between turn-on and turn-off thresholds
// - ov limit shows output format exponent
module pfcpm_regs
	import pfcpm_pkg::*;
(
	input  wire logic        clk,           // 10 MHz device clock
	input  wire logic        rst_n,         // async reset, active low
	input  wire logic        cmd_valid,     // one-cycle command strobe
	input  wire logic        cmd_write,     // 1 write or send byte
	input  wire logic [7:0]  cmd_code,      // command code
	input  wire logic [15:0] cmd_wdata,     // write data, low byte first
	input  wire logic        cmd_has_data,  // 0 for send byte
	input  wire logic        power_on_control_pin, // raw control pin
	input  wire logic [7:0]  vin_exp_reg,   // shared input exponent reg
	input  wire logic [10:0] vin_mantissa,  // measured input voltage
	input  wire logic        vin_valid,     // new input sample
	input  wire logic        fault_any,     // fault events from loops
	input  wire logic        nv_done,       // eeprom transfer finished
	input  wire logic [15:0] nv_rdata,      // restore word from eeprom
	output logic [15:0]      cmd_rdata,     // read answer
	output logic             cmd_ack,       // answer strobe
	output logic             cmd_refused,   // write rejected by lock or unknown code
	output logic             converter_on,  // enable for power stage
	output logic             fault_flag,    // sticky fault summary
	output logic             fault_clear_pulse, // clears all faults
	output logic [1:0]       nv_request,    // store or restore busy
	output logic             nv_factory     // restore from defaults
);

	typedef struct packed {
		logic [7:0]  run;
		logic [7:0]  cfg;
		logic [7:0]  wl;
		logic [7:0]  fmt;
		logic [15:0] setp;
		logic [15:0] loop;
		logic [15:0] mon;
		logic [15:0] von;
		logic [15:0] voff;
		logic [15:0] ov;
		logic        in_range;
		logic        conv;
		logic        fault;
		logic        fclr;
		logic [15:0] rdata;
		logic        ack;
		logic        refused;
		pfcpm_nv_t   nv;
		logic        factory;
	} pfcpm_state_t;

	pfcpm_state_t st_r;
	pfcpm_state_t st_nxt;

	logic        wr_ok;
	logic        pin_active;
	logic        enable_req;
	logic [4:0]  vin_exp;
	logic [4:0]  out_exp;
	logic [15:0] rd_val;

	// writable-by-lock decode; lock level one (bit7) wins over levels two and three
	always_comb begin
		if (st_r.wl[WL1_BIT]) begin
			wr_ok = (cmd_code == CMD_WRITE_LOCK);
		end else if (st_r.wl[WL2_BIT]) begin
			wr_ok = (cmd_code == CMD_WRITE_LOCK) ||
				(cmd_code == CMD_RUN) ||
				(cmd_code == CMD_PAGE_ERASE);
		end else if (st_r.wl[WL3_BIT]) begin
			wr_ok = (cmd_code == CMD_WRITE_LOCK) ||
				(cmd_code == CMD_RUN) ||
				(cmd_code == CMD_PAGE_ERASE) ||
				(cmd_code == CMD_ONOFF) ||
				(cmd_code == CMD_SETPOINT);
		end else begin
			wr_ok = 1'b1;
		end
	end

	// control pin level and enable qualification
	always_comb begin
		pin_active = st_r.cfg[CFG_POL_BIT] ? power_on_control_pin
			: ~power_on_control_pin;
		if (!st_r.cfg[CFG_PUP_BIT]) begin
			enable_req = 1'b1;
		end else begin
			enable_req = (!st_r.cfg[CFG_CMD_BIT] ||
					st_r.run[RUN_EN_BIT]) &&
				(!st_r.cfg[CFG_PIN_BIT] || pin_active);
		end
	end

	// exponent sources shown in threshold and limit reads
	always_comb begin
		vin_exp = {{2{vin_exp_reg[VIN_EXP_LSB+2]}},
			vin_exp_reg[VIN_EXP_LSB +: 3]};
		out_exp = {{2{st_r.fmt[2]}}, st_r.fmt[2:0]};
	end

	// read multiplexer; fixed fields forced here, not stored
	always_comb begin
		case (cmd_code)
			CMD_RUN: rd_val = {8'h00,
				(st_r.run & RUN_WMASK) | RUN_FIXED};
			CMD_ONOFF: rd_val = {8'h00,
				(st_r.cfg & CFG_WMASK) | CFG_FIXED};
			CMD_WRITE_LOCK: rd_val = {8'h00, st_r.wl & WL_WMASK};
			CMD_FEATURE: rd_val = {8'h00, FEATURE_VAL};
			CMD_VOUT_FMT: rd_val = {8'h00,
				(st_r.fmt & FMT_WMASK) | VOUT_FMT_LIN};
			CMD_SETPOINT: rd_val = st_r.setp & SET_WMASK;
			CMD_LOOP_SCALE: rd_val = st_r.loop & LOOP_WMASK;
			CMD_MON_SCALE: rd_val = st_r.mon & MON_WMASK;
			CMD_INPUT_TURN_ON_THRESHOLD: rd_val = {vin_exp,
				st_r.von[10:0]};
			CMD_INPUT_TURN_OFF_THRESHOLD: rd_val = {vin_exp,
				st_r.voff[10:0]};
			CMD_OV_LIMIT: rd_val = {out_exp,
				st_r.ov[10:0]};
			default: rd_val = 16'h0000;
		endcase
	end

	// next-state: bus writes, send-byte commands, run control
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.refused = 1'b0;
		st_nxt.fclr = 1'b0;
		if (nv_done) begin
			st_nxt.nv = PFCPM_NV_IDLE;
		end
		// fault flag: set wins over clear in the same cycle
		if (fault_any) begin
			st_nxt.fault = 1'b1;
		end
		if (cmd_valid) begin
			st_nxt.ack = 1'b1;
			st_nxt.rdata = rd_val;
			if (cmd_write && !wr_ok) begin
				st_nxt.refused = 1'b1;
			end else if (cmd_write && !cmd_has_data) begin
				case (cmd_code)
					CMD_FAULT_CLEAR: begin
						st_nxt.fclr = 1'b1;
						st_nxt.fault = fault_any;
					end
					CMD_RESTORE_DEF: begin
						st_nxt.nv = PFCPM_NV_RESTORE;
						st_nxt.factory = 1'b1;
						st_nxt.run = DEF_RUN;
						st_nxt.cfg = DEF_CFG;
						st_nxt.fmt = DEF_FMT;
						st_nxt.setp = DEF_SET;
						st_nxt.loop = DEF_LOOP;
						st_nxt.mon = DEF_MON;
						st_nxt.von = DEF_VON;
						st_nxt.voff = DEF_VOFF;
						st_nxt.ov = DEF_OV;
					end
					CMD_STORE_USER: begin
						st_nxt.nv = PFCPM_NV_STORE;
						st_nxt.factory = 1'b0;
					end
					CMD_RESTORE_USER: begin
						st_nxt.nv = PFCPM_NV_RESTORE;
						st_nxt.factory = 1'b0;
					end
					default: st_nxt.refused = 1'b1;
				endcase
			end else if (cmd_write) begin
				case (cmd_code)
					CMD_RUN: st_nxt.run =
						cmd_wdata[7:0] & RUN_WMASK;
					CMD_ONOFF: st_nxt.cfg =
						cmd_wdata[7:0] & CFG_WMASK;
					CMD_WRITE_LOCK: st_nxt.wl =
						cmd_wdata[7:0] & WL_WMASK;
					CMD_VOUT_FMT: st_nxt.fmt =
						cmd_wdata[7:0] & FMT_WMASK;
					CMD_SETPOINT: st_nxt.setp =
						cmd_wdata & SET_WMASK;
					CMD_LOOP_SCALE: st_nxt.loop =
						cmd_wdata & LOOP_WMASK;
					CMD_MON_SCALE: st_nxt.mon =
						cmd_wdata & MON_WMASK;
					CMD_INPUT_TURN_ON_THRESHOLD: st_nxt.von =
						cmd_wdata & MANT11_WMASK;
					CMD_INPUT_TURN_OFF_THRESHOLD: st_nxt.voff =
						cmd_wdata & MANT11_WMASK;
					CMD_OV_LIMIT: st_nxt.ov =
						cmd_wdata & MANT11_WMASK;
					default: st_nxt.refused = 1'b1;
				endcase
			end
		end
		// user restore word lands in the setpoint image
		if (st_r.nv == PFCPM_NV_RESTORE && !st_r.factory && nv_done) begin
			st_nxt.setp = nv_rdata & SET_WMASK;
		end
		if (vin_valid) begin
			if (vin_mantissa >= st_r.von[10:0]) begin
				st_nxt.in_range = 1'b1;
			end else if (vin_mantissa <= st_r.voff[10:0]) begin
				st_nxt.in_range = 1'b0;
			end
		end
		st_nxt.conv = enable_req && st_nxt.in_range;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{run: DEF_RUN, cfg: DEF_CFG, wl: DEF_WL,
				fmt: DEF_FMT, setp: DEF_SET, loop: DEF_LOOP,
				mon: DEF_MON, von: DEF_VON, voff: DEF_VOFF,
				ov: DEF_OV, in_range: 1'b0, conv: 1'b0,
				fault: 1'b0, fclr: 1'b0, rdata: 16'h0000,
				ack: 1'b0, refused: 1'b0, nv: PFCPM_NV_IDLE,
				factory: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_rdata         = st_r.rdata;
	assign cmd_ack           = st_r.ack;
	assign cmd_refused       = st_r.refused;
	assign converter_on      = st_r.conv;
	assign fault_flag        = st_r.fault;
	assign fault_clear_pulse = st_r.fclr;
	assign nv_request        = st_r.nv;
	assign nv_factory        = st_r.factory;

	// checks
	property p_run_off;
		@(posedge clk) disable iff (!rst_n)
		(st_r.cfg[CFG_PUP_BIT] && st_r.cfg[CFG_CMD_BIT] &&
			!st_r.run[RUN_EN_BIT]) |=> !converter_on;
	endproperty
	a_run_off: assert property (p_run_off)
		else $error("converter on while run bit clear");

	sequence s_read(logic [7:0] c);
		cmd_valid && !cmd_write && cmd_code == c;
	endsequence

	property p_run_fixed;
		@(posedge clk) disable iff (!rst_n)
		s_read(CMD_RUN) |=> cmd_ack && cmd_rdata[6:0] == RUN_FIXED[6:0];
	endproperty
	a_run_fixed: assert property (p_run_fixed)
		else $error("run fixed fields wrong");

	property p_pin_gate;
		@(posedge clk) disable iff (!rst_n)
		(st_r.cfg[CFG_PUP_BIT] && st_r.cfg[CFG_PIN_BIT] && !pin_active)
			|=> !converter_on;
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("converter on with pin inactive");

	property p_cfg_bit0;
		@(posedge clk) disable iff (!rst_n)
		s_read(CMD_ONOFF) |=> cmd_rdata[0];
	endproperty
	a_cfg_bit0: assert property (p_cfg_bit0)
		else $error("config bit0 not one");

	property p_fclr;
		@(posedge clk) disable iff (!rst_n)
		(cmd_valid && cmd_write && !cmd_has_data &&
			cmd_code == CMD_FAULT_CLEAR && wr_ok && !fault_any)
			|=> fault_clear_pulse && !fault_flag ##1 !fault_clear_pulse;
	endproperty
	a_fclr: assert property (p_fclr)
		else $error("fault clear not done");

	property p_lock1;
		@(posedge clk) disable iff (!rst_n)
		(cmd_valid && cmd_write && st_r.wl[WL1_BIT] &&
			cmd_code != CMD_WRITE_LOCK) |=> cmd_refused &&
			$stable(st_r.setp) && $stable(st_r.run);
	endproperty
	a_lock1: assert property (p_lock1)
		else $error("write passed lock level one");

	property p_feature;
		@(posedge clk) disable iff (!rst_n)
		s_read(CMD_FEATURE) |=> cmd_rdata == {8'h00, FEATURE_VAL};
	endproperty
	a_feature: assert property (p_feature)
		else $error("feature report wrong");

	property p_setp_top;
		@(posedge clk) disable iff (!rst_n)
		s_read(CMD_SETPOINT) |=> cmd_rdata[15:12] == 4'h0;
	endproperty
	a_setp_top: assert property (p_setp_top)
		else $error("setpoint top bits nonzero");

	// lock levels two and three, store request, input window start
	sequence s_write(logic [7:0] c);
		cmd_valid && cmd_write && cmd_has_data && cmd_code == c;
	endsequence

	property p_lock2;
		@(posedge clk) disable iff (!rst_n)
		(!st_r.wl[WL1_BIT] && st_r.wl[WL2_BIT]) ##0 s_write(CMD_ONOFF)
			|=> cmd_refused && $stable(st_r.cfg);
	endproperty
	a_lock2: assert property (p_lock2)
		else $error("write passed lock level two");

	property p_lock3;
		@(posedge clk) disable iff (!rst_n)
		(!st_r.wl[WL1_BIT] && !st_r.wl[WL2_BIT] && st_r.wl[WL3_BIT])
			##0 s_write(CMD_LOOP_SCALE)
			|=> cmd_refused && $stable(st_r.loop);
	endproperty
	a_lock3: assert property (p_lock3)
		else $error("write passed lock level three");

	property p_store;
		@(posedge clk) disable iff (!rst_n)
		(cmd_valid && cmd_write && !cmd_has_data && wr_ok &&
			cmd_code == CMD_STORE_USER)
			|=> nv_request == PFCPM_NV_STORE;
	endproperty
	a_store: assert property (p_store)
		else $error("store request not raised");

	property p_range_on;
		@(posedge clk) disable iff (!rst_n)
		(vin_valid && vin_mantissa >= st_r.von[10:0] && enable_req)
			|=> converter_on;
	endproperty
	a_range_on: assert property (p_range_on)
		else $error("converter not started at turn-on level");
endmodule

// ==== logic/pfcpm_pkg.sv ====
package pfcpm_pkg;
	// command codes
	localparam logic [7:0] CMD_RUN          = 8'h01;
	localparam logic [7:0] CMD_ONOFF        = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLEAR  = 8'h03;
	localparam logic [7:0] CMD_WRITE_LOCK   = 8'h10;
	localparam logic [7:0] CMD_RESTORE_DEF  = 8'h12;
	localparam logic [7:0] CMD_STORE_USER   = 8'h15;
	localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
	localparam logic [7:0] CMD_FEATURE      = 8'h19;
	localparam logic [7:0] CMD_VOUT_FMT     = 8'h20;
	localparam logic [7:0] CMD_SETPOINT     = 8'h21;
	localparam logic [7:0] CMD_LOOP_SCALE   = 8'h29;
	localparam logic [7:0] CMD_MON_SCALE    = 8'h2a;
	localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD       = 8'h35;
	localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD      = 8'h36;
	localparam logic [7:0] CMD_OV_LIMIT     = 8'h40;
	localparam logic [7:0] CMD_PAGE_ERASE   = 8'hd4;
	// bit positions
	localparam int RUN_EN_BIT    = 7;
	localparam int CFG_PUP_BIT   = 4;
	localparam int CFG_CMD_BIT   = 3;
	localparam int CFG_PIN_BIT   = 2;
	localparam int CFG_POL_BIT   = 1;
	localparam int WL1_BIT       = 7;
	localparam int WL2_BIT       = 6;
	localparam int WL3_BIT       = 5;
	// fixed read values
	localparam logic [7:0] RUN_FIXED     = 8'h04; // margin 00, resp 01
	localparam logic [7:0] CFG_FIXED     = 8'h01; // power-down bit = 1
	localparam logic [7:0] FEATURE_VAL   = 8'h20; // no pec, 400k, no alert
	localparam logic [7:0] VOUT_FMT_LIN  = 8'h00; // linear mode code
	localparam logic [7:0] RUN_WMASK     = 8'h80;
	localparam logic [7:0] CFG_WMASK     = 8'h1e;
	localparam logic [7:0] WL_WMASK      = 8'he0;
	localparam logic [7:0] FMT_WMASK     = 8'h07;
	localparam logic [15:0] SET_WMASK    = 16'h0fff;
	localparam logic [15:0] LOOP_WMASK   = 16'hfbff;
	localparam logic [15:0] MON_WMASK    = 16'h3bff;
	localparam logic [15:0] MANT11_WMASK = 16'h07ff;
	// default (factory) values; plain choices
	localparam logic [7:0]  DEF_RUN   = 8'h80;
	localparam logic [7:0]  DEF_CFG   = 8'h00;
	localparam logic [7:0]  DEF_WL    = 8'h00;
	localparam logic [7:0]  DEF_FMT   = 8'h00;
	localparam logic [15:0] DEF_SET   = 16'h0000;
	localparam logic [15:0] DEF_LOOP  = 16'h0000;
	localparam logic [15:0] DEF_MON   = 16'h0000;
	localparam logic [15:0] DEF_VON   = 16'h0000;
	localparam logic [15:0] DEF_VOFF  = 16'h0000;
	localparam logic [15:0] DEF_OV    = 16'h0000;
	localparam int VIN_EXP_LSB = 3; // exponent reg bits 5:3
	localparam int EXP_LSB     = 11;

	// nonvolatile image handshake kinds
	typedef enum logic [1:0] {
		PFCPM_NV_IDLE    = 2'b00,
		PFCPM_NV_RESTORE = 2'b01,
		PFCPM_NV_STORE   = 2'b10
	} pfcpm_nv_t;
endpackage

// ==== bench/pfcpm_host.sv ====
`timescale 1ns/1ps
// host side: issues commands and answers eeprom transfers
module pfcpm_host (
	input  wire logic        clk,          // device clock
	input  wire logic [15:0] cmd_rdata,    // read answer
	input  wire logic        cmd_ack,      // answer strobe
	input  wire logic        cmd_refused,  // write rejected
	input  wire logic [1:0]  nv_request,   // eeprom transfer request
	output logic             cmd_valid,    // command strobe
	output logic             cmd_write,    // write or send byte
	output logic [7:0]       cmd_code,     // command code
	output logic [15:0]      cmd_wdata,    // write data
	output logic             cmd_has_data, // 0 for send byte
	output logic             nv_done,      // transfer finished
	output logic [15:0]      nv_rdata      // restore word
);
	int          nv_wait = 4;
	int          nv_cnt  = 0;
	logic [15:0] got;
	logic        rej;
	logic        ack;

	// idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_has_data = 1'b0;
		nv_done = 1'b0;
		nv_rdata = 16'h5555;
	end

	// one strobe; answer taken while ack stands
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] d, input logic hd);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_wdata <= d;
		cmd_has_data <= hd;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_wdata <= ~d; // stale data must not look valid
		#1;
		ack = cmd_ack;
		got = cmd_rdata;
		rej = cmd_refused;
	endtask

	// eeprom answers after nv_wait cycles; word only valid with done
	always @(posedge clk) begin
		nv_done <= 1'b0;
		nv_rdata <= ~nv_rdata;
		if (nv_request != 2'b00 && !nv_done) begin
			nv_cnt <= nv_cnt + 1;
			if (nv_cnt >= nv_wait) begin
				nv_done <= 1'b1;
				nv_rdata <= 16'h0abc;
				nv_cnt <= 0;
			end
		end
	end
endmodule

// ==== bench/pfc_pmbus_standard_commands_tb.sv ====
`timescale 1ns/1ps
module pfc_pmbus_standard_commands_tb;
	import pfcpm_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, vin_valid = 1'b0;
	logic fault_any = 1'b0;
	logic [7:0] vin_exp_reg = 8'h28;
	logic [10:0] vin_mant = 11'h000;
	logic cmd_valid, cmd_write, cmd_has_data, nv_done;
	logic cmd_ack, cmd_refused, converter_on, fault_flag;
	logic fault_clear_pulse, nv_factory;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, nv_rdata, cmd_rdata;
	logic [1:0] nv_request;
	int errors = 0, num_checks = 0, cyc = 0, n_clr = 0;
	logic [7:0] codes [10] = '{CMD_RUN, CMD_ONOFF, CMD_FEATURE,
		CMD_VOUT_FMT, CMD_SETPOINT, CMD_LOOP_SCALE, CMD_MON_SCALE,
		CMD_INPUT_TURN_ON_THRESHOLD, CMD_INPUT_TURN_OFF_THRESHOLD, CMD_OV_LIMIT};
	logic [15:0] exps [10] = '{16'h0084, 16'h001f, 16'h0020, 16'h0007,
		16'h0fff, 16'hfbff, 16'h3bff, 16'hefff, 16'hefff, 16'hffff};
	logic [7:0] lk [3] = '{8'h80, 8'h40, 8'h20};
	logic [3:0] rej_tab [3] = '{4'b1111, 4'b1110, 4'b1000};
	logic [7:0] lc [4] = '{CMD_RUN, CMD_ONOFF, CMD_SETPOINT, CMD_LOOP_SCALE};

	always #50 clk = ~clk;

	pfcpm_regs uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_has_data(cmd_has_data), .power_on_control_pin(pin),
		.vin_exp_reg(vin_exp_reg), .vin_mantissa(vin_mant),
		.vin_valid(vin_valid), .fault_any(fault_any), .nv_done(nv_done),
		.nv_rdata(nv_rdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
		.cmd_refused(cmd_refused), .converter_on(converter_on),
		.fault_flag(fault_flag), .fault_clear_pulse(fault_clear_pulse),
		.nv_request(nv_request), .nv_factory(nv_factory));

	pfcpm_host host (.clk(clk), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
		.cmd_refused(cmd_refused), .nv_request(nv_request),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_has_data(cmd_has_data),
		.nv_done(nv_done), .nv_rdata(nv_rdata));

	task automatic wrap_up;
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		host.xfer(1'b0, c, 16'h0000, 1'b0);
		chk({15'h0000, host.ack}, 16'h0001);
		chk(host.got, e);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host.xfer(1'b1, c, d, 1'b1);
	endtask

	task automatic send(input logic [7:0] c);
		host.xfer(1'b1, c, 16'h0000, 1'b0);
	endtask

	// let a cause settle, then look at the power stage enable
	task automatic on_is(input logic e);
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0000, converter_on}, {15'h0000, e});
	endtask

	task automatic vin(input logic [10:0] v);
		@(posedge clk);
		vin_mant <= v;
		vin_valid <= 1'b1;
		@(posedge clk);
		vin_valid <= 1'b0;
	endtask

	task automatic set_pin(input logic v);
		@(posedge clk);
		pin <= v;
	endtask

	task automatic wait_nv;
		for (int k = 0; k < 50 && nv_request !== 2'b00; k++)
			@(posedge clk);
		#1;
		chk({14'h0000, nv_request}, 16'h0000);
	endtask

	// hang guard, the run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (fault_clear_pulse === 1'b1)
			n_clr++;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(CMD_RUN, 16'h0084);
		rd(CMD_ONOFF, 16'h0001);
		rd(CMD_WRITE_LOCK, 16'h0000);
		rd(CMD_FEATURE, 16'h0020);
		rd(CMD_VOUT_FMT, 16'h0000);
		// all ones into every register but the write lock, only writable bits stick
		for (int i = 0; i < 10; i++) begin
			wr(codes[i], 16'hffff);
			rd(codes[i], exps[i]);
		end
		wr(CMD_VOUT_FMT, 16'h0002);
		rd(CMD_OV_LIMIT, 16'h17ff);
		// enable logic, thresholds at 0x100 on and 0x080 off
		wr(CMD_INPUT_TURN_ON_THRESHOLD, 16'h0100);
		wr(CMD_INPUT_TURN_OFF_THRESHOLD, 16'h0080);
		wr(CMD_ONOFF, 16'h001e);
		vin(11'h120);
		on_is(1'b0);
		set_pin(1'b1);
		on_is(1'b1);
		wr(CMD_RUN, 16'h0000);
		on_is(1'b0);
		wr(CMD_ONOFF, 16'h0016);
		on_is(1'b1);
		wr(CMD_ONOFF, 16'h0014);
		on_is(1'b0);
		set_pin(1'b0);
		on_is(1'b1);
		set_pin(1'b1);
		wr(CMD_ONOFF, 16'h0000);
		on_is(1'b1);
		vin(11'h0ff);
		on_is(1'b1);
		vin(11'h080);
		on_is(1'b0);
		vin(11'h0ff);
		on_is(1'b0);
		vin(11'h100);
		on_is(1'b1);
		// sticky fault and its clear
		@(posedge clk);
		fault_any <= 1'b1;
		@(posedge clk);
		fault_any <= 1'b0;
		on_is(1'b1);
		chk({15'h0000, fault_flag}, 16'h0001);
		send(CMD_FAULT_CLEAR);
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, fault_flag}, 16'h0000);
		chk(16'(n_clr), 16'h0001);
		// each lock level against four targets
		for (int l = 0; l < 3; l++) begin
			wr(CMD_WRITE_LOCK, {8'h00, lk[l]});
			for (int j = 0; j < 4; j++) begin
				wr(lc[j], (j == 0) ? 16'h0080 : (j == 2) ? 16'h0123 : 16'h0000);
				chk({15'h0000, host.rej}, {15'h0000, rej_tab[l][j]});
			end
		end
		rd(CMD_LOOP_SCALE, 16'hfbff);
		rd(CMD_SETPOINT, 16'h0123);
		wr(CMD_WRITE_LOCK, 16'h001f);
		rd(CMD_WRITE_LOCK, 16'h0000);
		// store, user restore, factory restore
		send(CMD_STORE_USER);
		chk({14'h0000, nv_request}, 16'h0002);
		wait_nv();
		host.nv_wait = 0;
		send(CMD_RESTORE_USER);
		chk({14'h0000, nv_request}, 16'h0001);
		wait_nv();
		rd(CMD_SETPOINT, 16'h0abc);
		send(CMD_RESTORE_DEF);
		chk({15'h0000, nv_factory}, 16'h0001);
		wait_nv();
		rd(CMD_SETPOINT, 16'h0000);
		rd(CMD_RUN, 16'h0084);
		send(8'h7b);
		chk({15'h0000, host.rej}, 16'h0001);
		wrap_up();
	end
endmodule
